// file: rtl/debs_sequencer.sv
`timescale 1ns/1ps
`include "debs_regs.svh"
module debs_sequencer
    import debs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        hw_enable_pin,
    input  wire logic        sto_pin,
    input  wire logic        stop_input_pin,
    input  wire logic [15:0] velocity,
    input  wire logic [10:0] vbus_volts,
    input  wire logic [15:0] regen_power,
    output logic             power_stage_en,
    output logic             brake_apply,
    output logic             ctrl_stop_req,
    output logic             chopper_on,
    output logic             fault_contact,
    output logic             irq
);

    logic [`DEBS_CTRL_W-1:0] ctrl_ff;
    logic [15:0]             vthresh_ff;
    logic [31:0]             timeout_ff;
    logic [10:0]             uv_level_ff;
    logic [15:0]             rgn_warn_ff;
    logic [15:0]             rgn_fault_ff;
    logic [`DEBS_EVT_W-1:0]  evt_ff;
    logic [`DEBS_EVT_W-1:0]  mask_ff;
    logic [`DEBS_FLT_W-1:0]  fault_ff;
    logic                    regen_trip_ff;
    debs_state_t             state_ff;
    debs_state_t             nxt_state;
    logic [31:0]             stop_cnt_ff;
    logic                    hw_en_prev_ff;
    logic [31:0]             prdata_ff;
    logic                    pready_ff;
    logic                    pslverr_ff;
    logic                    power_ff;
    logic                    brake_ff;
    logic                    stop_req_ff;
    logic                    fault_contact_ff;
    logic                    irq_ff;

    logic [2:0]              pin_lvl;
    logic                    hw_en_s;
    logic                    sto_s;
    logic                    stop_in_s;
    logic                    sw_en;
    logic [1:0]              dis_mode;
    logic                    brk_imm;
    logic                    uv_mode;
    logic                    hi_mains;
    logic                    brk_fit;
    logic                    apb_setup;
    logic                    apb_wr;
    logic                    apb_rd;
    logic                    addr_ok;
    logic                    hw_rise;
    logic                    uv;
    logic                    ov;
    logic [10:0]             chop_thr;
    logic [10:0]             ov_lim;
    logic                    enabled;
    logic                    enabling;
    logic                    standstill;
    logic                    timed_out;
    logic                    rgn_warn;
    logic                    rgn_trip;
    logic                    chop_req;
    logic [`DEBS_FLT_W-1:0]  flt_set;
    logic [`DEBS_FLT_W-1:0]  nxt_fault;
    logic [`DEBS_EVT_W-1:0]  evt_set;
    logic [`DEBS_EVT_W-1:0]  nxt_evt;
    logic                    hard_off;
    logic                    stop_done;
    logic [31:0]             rd_mux;

    // ****************************************
    // Pin synchronisers and chopper limiter
    // ****************************************
    debs_pin_sync #(
        .W (3)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     ({stop_input_pin, sto_pin, hw_enable_pin}),
        .level   (pin_lvl)
    );

    assign hw_en_s   = pin_lvl[0];
    assign sto_s     = pin_lvl[1];
    assign stop_in_s = pin_lvl[2];

    debs_duty_limit u_duty (
        .pclk    (pclk),
        .presetn (presetn),
        .req     (chop_req),
        .chop_on (chopper_on)
    );

    // ****************************************
    // Control fields
    // ****************************************
    assign sw_en    = ctrl_ff[`DEBS_CTRL_SWEN];
    assign dis_mode = ctrl_ff[`DEBS_CTRL_DMODE_HI:`DEBS_CTRL_DMODE_LO];
    assign brk_imm  = ctrl_ff[`DEBS_CTRL_BRKIMM];
    assign uv_mode  = ctrl_ff[`DEBS_CTRL_UVMODE];
    assign hi_mains = ctrl_ff[`DEBS_CTRL_HIMAINS];
    assign brk_fit  = ctrl_ff[`DEBS_CTRL_BRKFIT];

    // ****************************************
    // Bus voltage and regen supervision
    // ****************************************
    assign chop_thr = hi_mains ? `DEBS_CHOP_ON_HI : `DEBS_CHOP_ON_LO;
    assign ov_lim   = hi_mains ? `DEBS_OV_LIM_HI : `DEBS_OV_LIM_LO;
    assign uv       = vbus_volts < uv_level_ff;
    assign ov       = vbus_volts > ov_lim;
    assign rgn_warn = regen_power > rgn_warn_ff;
    assign rgn_trip = regen_power > rgn_fault_ff;
    assign chop_req = (vbus_volts > chop_thr) && !regen_trip_ff;

    assign hw_rise    = hw_en_s && !hw_en_prev_ff;
    assign enabled    = (state_ff == st_active) || (state_ff == st_ctrl_stop);
    assign enabling   = (state_ff == st_off) && sw_en && hw_en_s;
    assign standstill = velocity < vthresh_ff;
    assign timed_out  = stop_cnt_ff >= timeout_ff;

    // ****************************************
    // Fault and event sources
    // ****************************************
    always_comb begin
        flt_set = '0;
        flt_set[`DEBS_FLT_UV] = uv && (!uv_mode
                                       || enabled || enabling);
        flt_set[`DEBS_FLT_STO] = hw_rise && !sto_s;
        flt_set[`DEBS_FLT_OV]  = ov;
    end

    assign stop_done = (nxt_state == st_off) && (state_ff != st_off);

    always_comb begin
        evt_set = '0;
        evt_set[`DEBS_EVT_UVFLT]    = flt_set[`DEBS_FLT_UV];
        evt_set[`DEBS_EVT_UVWARN]   = uv && uv_mode && !enabled
                                      && !enabling;
        evt_set[`DEBS_EVT_STOFLT]   = flt_set[`DEBS_FLT_STO];
        evt_set[`DEBS_EVT_OVFLT]    = flt_set[`DEBS_FLT_OV];
        evt_set[`DEBS_EVT_RGNWARN]  = rgn_warn;
        evt_set[`DEBS_EVT_RGNTRIP]  = rgn_trip;
        evt_set[`DEBS_EVT_STOPDONE] = stop_done;
    end

    // ****************************************
    // APB decode
    // ****************************************
    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && pready_ff && pwrite;
    assign apb_rd    = psel && penable && pready_ff && !pwrite;

    always_comb begin
        addr_ok = 1'b1;
        rd_mux  = 32'h0000_0000;
        case (paddr)
            `DEBS_OFS_CTRL:     rd_mux = {25'h0, ctrl_ff};
            `DEBS_OFS_VTHRESH:  rd_mux = {16'h0, vthresh_ff};
            `DEBS_OFS_TIMEOUT:  rd_mux = timeout_ff;
            `DEBS_OFS_UVLEVEL:  rd_mux = {21'h0, uv_level_ff};
            `DEBS_OFS_RGNWARN:  rd_mux = {16'h0, rgn_warn_ff};
            `DEBS_OFS_RGNFAULT: rd_mux = {16'h0, rgn_fault_ff};
            `DEBS_OFS_STATUS:   rd_mux = {22'h0, regen_trip_ff, uv,
                                          chopper_on, brake_ff, power_ff,
                                          fault_ff, state_ff};
            `DEBS_OFS_EVENTS:   rd_mux = {25'h0, evt_ff};
            `DEBS_OFS_MASK:     rd_mux = {25'h0, mask_ff};
            `DEBS_OFS_FLTCLR:   rd_mux = 32'h0000_0000;
            default:            addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= apb_setup;
            pslverr_ff <= apb_setup && !addr_ok;
            if (apb_setup && !pwrite) begin
                prdata_ff <= rd_mux;
            end
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff      <= `DEBS_CTRL_RST;
            vthresh_ff   <= `DEBS_VTHRESH_RST;
            timeout_ff   <= `DEBS_TIMEOUT_RST;
            uv_level_ff  <= `DEBS_UVLEVEL_RST;
            rgn_warn_ff  <= `DEBS_RGNWARN_RST;
            rgn_fault_ff <= `DEBS_RGNFAULT_RST;
            mask_ff      <= '0;
        end else if (apb_wr) begin
            case (paddr)
                `DEBS_OFS_CTRL:     ctrl_ff      <= pwdata[`DEBS_CTRL_W-1:0];
                `DEBS_OFS_VTHRESH:  vthresh_ff   <= pwdata[15:0];
                `DEBS_OFS_TIMEOUT:  timeout_ff   <= pwdata;
                `DEBS_OFS_UVLEVEL:  uv_level_ff  <= pwdata[10:0];
                `DEBS_OFS_RGNWARN:  rgn_warn_ff  <= pwdata[15:0];
                `DEBS_OFS_RGNFAULT: rgn_fault_ff <= pwdata[15:0];
                `DEBS_OFS_MASK:     mask_ff      <= pwdata[`DEBS_EVT_W-1:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Latched faults, regen trip, sticky events
    // ****************************************
    always_comb begin
        nxt_fault = fault_ff;
        if (apb_wr && paddr == `DEBS_OFS_FLTCLR) begin
            nxt_fault = fault_ff & ~pwdata[`DEBS_FLT_W-1:0];
        end
        nxt_fault = nxt_fault | flt_set;
    end

    always_comb begin
        nxt_evt = evt_ff;
        if (apb_rd && paddr == `DEBS_OFS_EVENTS) begin
            nxt_evt = '0;
        end
        nxt_evt = nxt_evt | evt_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_ff <= '0;
            evt_ff   <= '0;
        end else begin
            fault_ff <= nxt_fault;
            evt_ff   <= nxt_evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regen_trip_ff <= 1'b0;
        end else if (rgn_trip) begin
            regen_trip_ff <= 1'b1;
        end else if (apb_wr && paddr == `DEBS_OFS_FLTCLR) begin
            regen_trip_ff <= 1'b0;
        end
    end

    // ****************************************
    // Enable / stop sequencer
    // ****************************************
    assign hard_off = !hw_en_s || !sto_s || (|fault_ff) || (|flt_set);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            st_off: begin
                if (enabling && sto_s && !stop_in_s && !uv
                    && !(|fault_ff) && !(|flt_set)) begin
                    nxt_state = st_active;
                end
            end
            st_active: begin
                if (hard_off) begin
                    nxt_state = brk_imm ? st_off
                                        : st_brake_wait;
                end else if (!sw_en) begin
                    nxt_state = (dis_mode == 2'd2) ? st_ctrl_stop
                                                   : st_brake_wait;
                end else if (stop_in_s) begin
                    nxt_state = st_ctrl_stop;
                end
            end
            st_ctrl_stop: begin
                if (hard_off) begin
                    nxt_state = brk_imm ? st_off : st_brake_wait;
                end else if (standstill || timed_out) begin
                    nxt_state = st_off;
                end
            end
            st_brake_wait: begin
                if (standstill || timed_out
                    || (brk_imm && hard_off)) begin
                    nxt_state = st_off;
                end
            end
            default: nxt_state = st_off;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff      <= st_off;
            hw_en_prev_ff <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            hw_en_prev_ff <= hw_en_s;
        end
    end

    // ****************************************
    // Stop timeout counter, restarts at stop begin
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_cnt_ff <= 32'h0000_0000;
        end else if (state_ff == st_active || state_ff == st_off) begin
            stop_cnt_ff <= 32'h0000_0000;
        end else if (!timed_out) begin
            stop_cnt_ff <= stop_cnt_ff + 32'd1;
        end
    end

    // ****************************************
    // Output flops
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_ff         <= 1'b0;
            brake_ff         <= 1'b0;
            stop_req_ff      <= 1'b0;
            fault_contact_ff <= 1'b0;
            irq_ff           <= 1'b0;
        end else begin
            power_ff <= (nxt_state == st_active)
                        || (nxt_state == st_ctrl_stop);
            brake_ff <= brk_fit && (nxt_state == st_off);
            stop_req_ff      <= nxt_state == st_ctrl_stop;
            fault_contact_ff <= !(|nxt_fault);
            irq_ff           <= |(nxt_evt & mask_ff);
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign power_stage_en = power_ff;
    assign brake_apply    = brake_ff;
    assign ctrl_stop_req  = stop_req_ff;
    assign fault_contact  = fault_contact_ff;
    assign irq            = irq_ff;

endmodule : debs_sequencer

// file: shared/debs_regs.svh
`ifndef DEBS_REGS_SVH
`define DEBS_REGS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define DEBS_OFS_CTRL      8'h00
`define DEBS_OFS_VTHRESH   8'h04
`define DEBS_OFS_TIMEOUT   8'h08
`define DEBS_OFS_UVLEVEL   8'h0c
`define DEBS_OFS_RGNWARN   8'h10
`define DEBS_OFS_RGNFAULT  8'h14
`define DEBS_OFS_STATUS    8'h18
`define DEBS_OFS_EVENTS    8'h1c
`define DEBS_OFS_MASK      8'h20
`define DEBS_OFS_FLTCLR    8'h24

// ****************************************
// Control register fields
// ****************************************
`define DEBS_CTRL_SWEN     0
`define DEBS_CTRL_DMODE_LO 1
`define DEBS_CTRL_DMODE_HI 2
`define DEBS_CTRL_BRKIMM   3
`define DEBS_CTRL_UVMODE   4
`define DEBS_CTRL_HIMAINS  5
`define DEBS_CTRL_BRKFIT   6
`define DEBS_CTRL_W        7
`define DEBS_CTRL_RST      7'h50

// ****************************************
// Event and fault bits
// ****************************************
`define DEBS_EVT_UVFLT     0
`define DEBS_EVT_UVWARN    1
`define DEBS_EVT_STOFLT    2
`define DEBS_EVT_OVFLT     3
`define DEBS_EVT_RGNWARN   4
`define DEBS_EVT_RGNTRIP   5
`define DEBS_EVT_STOPDONE  6
`define DEBS_EVT_W         7
`define DEBS_FLT_UV        0
`define DEBS_FLT_STO       1
`define DEBS_FLT_OV        2
`define DEBS_FLT_W         3

// ****************************************
// Reset values and thresholds
// ****************************************
`define DEBS_VTHRESH_RST   16'h0064
`define DEBS_TIMEOUT_RST   32'h00030d40
`define DEBS_UVLEVEL_RST   11'h0c8
`define DEBS_RGNWARN_RST   16'h0200
`define DEBS_RGNFAULT_RST  16'h0300
`define DEBS_CHOP_ON_LO    11'd380
`define DEBS_CHOP_ON_HI    11'd760
`define DEBS_OV_LIM_LO     11'd420
`define DEBS_OV_LIM_HI     11'd840
`define DEBS_DUTY_WIN      8'd100
`define DEBS_DUTY_PCT      8'd15

`endif

// file: shared/debs_pkg.sv
package debs_pkg;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        st_off        = 2'b00,
        st_active     = 2'b01,
        st_ctrl_stop  = 2'b10,
        st_brake_wait = 2'b11
    } debs_state_t;

endpackage : debs_pkg

// file: rtl/debs_pin_sync.sv
`timescale 1ns/1ps
module debs_pin_sync #(
    parameter int W = 3
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);

    // ****************************************
    // Three stages, accept when 2nd and 3rd agree
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic out_ff;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_ff  <= 1'b0;
                    s2_ff  <= 1'b0;
                    s3_ff  <= 1'b0;
                    out_ff <= 1'b0;
                end else begin
                    s1_ff <= pin[i];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    if (s2_ff == s3_ff) begin
                        out_ff <= s3_ff;
                    end
                end
            end
            assign level[i] = out_ff;
        end
    endgenerate

endmodule : debs_pin_sync

// file: rtl/debs_duty_limit.sv
`timescale 1ns/1ps
`include "debs_regs.svh"
module debs_duty_limit (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic req,
    output logic      chop_on
);

    localparam logic [15:0] MAX_ON_W =
        (16'(`DEBS_DUTY_WIN) * 16'(`DEBS_DUTY_PCT)) / 16'd100;
    localparam logic [7:0] MAX_ON = MAX_ON_W[7:0];

    logic [7:0] win_cnt_ff;
    logic [7:0] on_cnt_ff;
    logic       chop_ff;
    logic       nxt_chop;

    // ****************************************
    // On time per window capped at the duty limit
    // ****************************************
    assign nxt_chop = req && (on_cnt_ff < MAX_ON);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt_ff <= 8'h00;
            on_cnt_ff  <= 8'h00;
            chop_ff    <= 1'b0;
        end else begin
            chop_ff <= nxt_chop;
            if (win_cnt_ff == `DEBS_DUTY_WIN - 8'd1) begin
                win_cnt_ff <= 8'h00;
                on_cnt_ff  <= 8'h00;
            end else begin
                win_cnt_ff <= win_cnt_ff + 8'd1;
                on_cnt_ff  <= on_cnt_ff + {7'h00, nxt_chop};
            end
        end
    end

    assign chop_on = chop_ff;

endmodule : debs_duty_limit

// file: test/debs_load_model.sv
`timescale 1ns/1ps
module debs_load_model (
    input  wire logic        pclk,
    input  wire logic        power_stage_en,
    input  wire logic        ctrl_stop_req,
    input  wire logic        hold,
    input  wire logic [15:0] speed_set,
    output logic      [15:0] velocity
);
    initial velocity = 16'h0000;
    // Held load keeps turning; else follows drive or slows down
    always @(posedge pclk) begin
        if (!hold) begin
            velocity <= (power_stage_en && !ctrl_stop_req) ? speed_set :
                        (velocity > 16'd16) ? velocity - 16'd16 : 16'h0;
        end
    end
endmodule : debs_load_model

// file: test/debs_sequencer_monitor.sv
`timescale 1ns/1ps
module debs_sequencer_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        hw_enable_pin,
    input wire logic        sto_pin,
    input wire logic [10:0] vbus_volts,
    input wire logic        power_stage_en,
    input wire logic        brake_apply,
    input wire logic        ctrl_stop_req,
    input wire logic        chopper_on,
    input wire logic        fault_contact
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [7:0] on_run_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_run_ff <= 8'h00;
        end else begin
            on_run_ff <= chopper_on ? on_run_ff + 8'h01 : 8'h00;
        end
    end
    property p_brk; power_stage_en |-> !brake_apply; endproperty
    a_brk: assert property (p_brk)
        else $error("brake with power on");
    property p_hw; !hw_enable_pin [*6] |-> !power_stage_en; endproperty
    a_hw: assert property (p_hw)
        else $error("power on without enable");
    property p_duty; on_run_ff <= 8'd30; endproperty
    a_duty: assert property (p_duty)
        else $error("chopper on too long");
    property p_ov;
        vbus_volts > 11'd840 |-> ##[1:4] !fault_contact;
    endproperty
    a_ov: assert property (p_ov)
        else $error("no overvoltage fault");
    property p_flt; !fault_contact [*2] |-> !power_stage_en; endproperty
    a_flt: assert property (p_flt)
        else $error("power on with fault");
    property p_stop; $rose(ctrl_stop_req) |-> power_stage_en; endproperty
    a_stop: assert property (p_stop)
        else $error("stop began without power");
    property p_sto;
        !hw_enable_pin ##1 (hw_enable_pin && !sto_pin) [*6]
            |-> ##[0:3] !fault_contact;
    endproperty
    a_sto: assert property (p_sto)
        else $error("no torque off fault");
    property p_chop; vbus_volts <= 11'd380 [*3] |=> !chopper_on; endproperty
    a_chop: assert property (p_chop)
        else $error("chopper on at low bus");
endmodule : debs_sequencer_monitor

bind debs_sequencer debs_sequencer_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .hw_enable_pin(hw_enable_pin),
    .sto_pin(sto_pin), .vbus_volts(vbus_volts),
    .power_stage_en(power_stage_en), .brake_apply(brake_apply),
    .ctrl_stop_req(ctrl_stop_req), .chopper_on(chopper_on),
    .fault_contact(fault_contact)
);

// file: test/drive_enable_brake_sequencer_tb.sv
`timescale 1ns/1ps
`include "debs_regs.svh"
module drive_enable_brake_sequencer_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        hw_enable_pin, sto_pin, stop_input_pin, irq, hold, rerr;
    logic        power_stage_en, brake_apply, ctrl_stop_req;
    logic        chopper_on, fault_contact;
    logic [7:0]  paddr;
    logic [10:0] vbus_volts;
    logic [15:0] velocity, regen_power, speed_set;
    logic [31:0] pwdata, prdata, rdq;
    int          n_errors, n_tests, n_on;
    wire  [4:0]  obs = {chopper_on, fault_contact, ctrl_stop_req,
                        brake_apply, power_stage_en};
    debs_sequencer dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hw_enable_pin(hw_enable_pin), .sto_pin(sto_pin),
        .stop_input_pin(stop_input_pin), .velocity(velocity),
        .vbus_volts(vbus_volts), .regen_power(regen_power),
        .power_stage_en(power_stage_en), .brake_apply(brake_apply),
        .ctrl_stop_req(ctrl_stop_req), .chopper_on(chopper_on),
        .fault_contact(fault_contact), .irq(irq)
    );
    debs_load_model u_load (
        .pclk(pclk), .power_stage_en(power_stage_en), .hold(hold),
        .ctrl_stop_req(ctrl_stop_req), .speed_set(speed_set),
        .velocity(velocity)
    );
    task automatic complete_run();
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdq = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wo(input int i, input logic v, input int lim);
        int n;
        n = 0;
        while (obs[i] !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(obs[i]), 32'(v));
    endtask : wo
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #50000;
        n_errors++;
        complete_run();
    end
    initial begin
        {psel, penable, pwrite, presetn, hold, stop_input_pin} = '0;
        {paddr, pwdata, regen_power} = '0;
        {hw_enable_pin, sto_pin} = 2'b11;
        n_errors = 0;
        n_tests = 0;
        void'($urandom(59));
        speed_set = 16'h0100 + 16'($urandom % 1024);
        vbus_volts = 11'd250 + 11'($urandom % 120);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h3c, 32'h0);
        chk(32'(rerr), 32'h1);
        chk(32'(brake_apply), 32'h1);
        apb(1'b1, `DEBS_OFS_TIMEOUT, 32'd20);
        apb(1'b1, `DEBS_OFS_CTRL, 32'h41);
        wo(0, 1'b1, 20);
        chk(32'(brake_apply), 32'h0);
        hold <= 1'b1;
        apb(1'b1, `DEBS_OFS_CTRL, 32'h40);
        wo(0, 1'b0, 6);
        repeat (6) @(posedge pclk);
        chk(32'(brake_apply), 32'h0);
        wo(1, 1'b1, 20);
        hold <= 1'b0;
        $display("test mode0 done");
        apb(1'b1, `DEBS_OFS_TIMEOUT, 32'd400);
        apb(1'b1, `DEBS_OFS_CTRL, 32'h45);
        wo(0, 1'b1, 20);
        apb(1'b1, `DEBS_OFS_CTRL, 32'h44);
        wo(2, 1'b1, 6);
        chk(32'(power_stage_en), 32'h1);
        wo(1, 1'b1, 120);
        chk(32'({power_stage_en, ctrl_stop_req}), 32'h0);
        $display("test mode2 done");
        apb(1'b1, `DEBS_OFS_CTRL, 32'h49);
        wo(0, 1'b1, 20);
        hold <= 1'b1;
        hw_enable_pin <= 1'b0;
        wo(0, 1'b0, 8);
        wo(1, 1'b1, 2);
        hold <= 1'b0;
        $display("test hw disable done");
        apb(1'b1, `DEBS_OFS_MASK, 32'h04);
        sto_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        hw_enable_pin <= 1'b1;
        wo(3, 1'b0, 10);
        repeat (20) @(posedge pclk);
        chk(32'({irq, power_stage_en}), 32'h2);
        apb(1'b0, `DEBS_OFS_EVENTS, 32'h0);
        chk(rdq & 32'h4, 32'h4);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0);
        sto_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b1, `DEBS_OFS_FLTCLR, 32'h7);
        wo(0, 1'b1, 20);
        $display("test torque off done");
        apb(1'b1, `DEBS_OFS_CTRL, 32'h58);
        wo(1, 1'b1, 120);
        apb(1'b0, `DEBS_OFS_EVENTS, 32'h0);
        vbus_volts <= 11'd100;
        repeat (8) @(posedge pclk);
        apb(1'b0, `DEBS_OFS_EVENTS, 32'h0);
        chk(32'({rdq[1:0], 1'b0, fault_contact}), 32'h9);
        apb(1'b1, `DEBS_OFS_CTRL, 32'h59);
        wo(3, 1'b0, 8);
        vbus_volts <= 11'd300;
        repeat (8) @(posedge pclk);
        apb(1'b1, `DEBS_OFS_FLTCLR, 32'h7);
        wo(0, 1'b1, 20);
        $display("test undervoltage done");
        stop_input_pin <= 1'b1;
        wo(2, 1'b1, 8);
        wo(1, 1'b1, 120);
        chk(32'(power_stage_en), 32'h0);
        stop_input_pin <= 1'b0;
        wo(0, 1'b1, 20);
        $display("test stop input done");
        vbus_volts <= 11'd390;
        wo(4, 1'b1, 8);
        n_on = 0;
        repeat (400) begin
            @(posedge pclk);
            n_on += int'(chopper_on);
        end
        chk(32'(n_on > 0 && n_on <= 75), 32'h1);
        regen_power <= 16'h0400;
        wo(4, 1'b0, 4);
        vbus_volts <= 11'd850;
        wo(3, 1'b0, 4);
        chk(32'(power_stage_en), 32'h0);
        $display("test regen done");
        complete_run();
    end
endmodule : drive_enable_brake_sequencer_tb
